// ---- pkg/synth_cal_pkg.sv ----
// Constants and carrier types for the synthesizer calibration register slice
package synth_cal_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_LO_BIAS = 8'h19;
	localparam logic [7:0] IDX_LOOP_GAIN = 8'h1a;
	localparam logic [7:0] IDX_TUNE_CTRL = 8'h1b;
	localparam logic [7:0] IDX_AMP_LEVEL = 8'h1c;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
	localparam logic [7:0] IDX_CAL_STATUS = 8'h32;
	localparam logic [7:0] IDX_PIN_ROUTE = 8'h33;

	// Values after reset
	localparam logic [7:0] RST_LO_BIAS = 8'h45;
	localparam logic [7:0] RST_LOOP_GAIN = 8'h86;
	localparam logic [7:0] RST_TUNE_CTRL = 8'h0d;
	localparam logic [7:0] RST_AMP_LEVEL = 8'h0f;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [3:0] RST_PIN_ROUTE = 4'h0;

	// Bit positions in the bias, tune control and amplifier level registers
	localparam int POS_PRESC_BIAS = 6;
	localparam int POS_LO_DRIVE = 0;
	localparam int POS_START = 7;
	localparam int POS_STORE_BOTH = 6;
	localparam int POS_DIV_CODE = 4;
	localparam int POS_ROUTINE = 3;
	localparam int POS_DAC_SEED = 0;
	localparam int POS_STRONG = 4;
	localparam int POS_WEAK = 0;

	// Interrupt status bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_START = 1;

	// Calibration clock dividers, new routine then legacy routine
	localparam logic [8:0] DIV_NEW_0 = 9'h008;
	localparam logic [8:0] DIV_NEW_1 = 9'h010;
	localparam logic [8:0] DIV_NEW_2 = 9'h028;
	localparam logic [8:0] DIV_NEW_3 = 9'h050;
	localparam logic [8:0] DIV_OLD_0 = 9'h050;
	localparam logic [8:0] DIV_OLD_1 = 9'h080;
	localparam logic [8:0] DIV_OLD_2 = 9'h0a0;
	localparam logic [8:0] DIV_OLD_3 = 9'h100;

	// Status pin sources: constant zero, constant one and the done flag
	localparam logic [3:0] PIN_SRC_ZERO = 4'h0;
	localparam logic [3:0] PIN_SRC_ONE = 4'h1;
	localparam logic [3:0] PIN_SRC_CAL_DONE = 4'h5;

	// Legacy calibration length in reference periods, per divider code
	localparam int LEGACY_REF_0 = 90000;
	localparam int LEGACY_REF_1 = 110000;
	localparam int LEGACY_REF_2 = 200000;
	// Reference periods per divider unit for the new routine
	localparam int NEW_REF_PER_DIV = 1024;
	localparam int CAL_CNT_W = 18;

	// Decoded settings handed to the analog side
	typedef struct packed {
		logic [1:0] presc_bias;
		logic [2:0] lo_drive;
		logic [7:0] loop_gain;
		logic store_both;
		logic routine_new;
		logic [8:0] cal_div;
		logic [3:0] tune_dac_seed;
		logic [3:0] strong_amp_level;
		logic [3:0] weak_amp_level;
	} synth_cfg_t;

	// Calibration state
	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN = 1'b1
	} cal_state_t;
endpackage

// ---- design/synth_cal_regs.sv ----
// Calibration and PA configuration register slice with Wishbone slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Prescaler bias code in bias register top bits, resets to 1.
// - LO drive code in bias register low bits, resets to 5.
// - Loop gain register resets to 134; software loads the computed value.
// - Rising edge of the start bit launches a calibration; resets to 0.
// - Store-both sends results to sets A and B, else selected set.
// - New routine maps divider codes 0..3 to 8, 16, 40, 80.
// - Legacy routine maps divider codes 0..3 to 80, 128, 160, 256.
// - Legacy calibration lasts about 90000, 110000 or 200000 periods.
// - Routine select resets to 1, choosing the new routine.
// - DAC seed resets to 5; start value is code plus one.
// - Strong amplifier level in upper nibble, resets to 0, 0 is off.
// - Weak amplifier level in lower nibble, resets to 15, 0 is off.
// - Active low done flag reaches status pin when source is 5.
module synth_cal_regs #(
	parameter int LEGACY_CNT_0 = synth_cal_pkg::LEGACY_REF_0,
	parameter int LEGACY_CNT_1 = synth_cal_pkg::LEGACY_REF_1,
	parameter int LEGACY_CNT_2 = synth_cal_pkg::LEGACY_REF_2,
	parameter int NEW_CNT_PER_DIV = synth_cal_pkg::NEW_REF_PER_DIV
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic freq_bank_sel,
	output synth_cal_pkg::synth_cfg_t cfg,
	output logic cal_busy,
	output logic cal_store_a,
	output logic cal_store_b,
	output logic cal_done_n,
	output logic status_pin,
	output logic irq
);
	logic [7:0] lo_bias_r;
	logic [7:0] loop_gain_r;
	logic [7:0] tune_ctrl_r;
	logic [7:0] amp_level_r;
	logic [1:0] irq_status_r;
	logic [1:0] irq_mask_r;
	logic [3:0] pin_route_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic start_prev_r;
	synth_cal_pkg::cal_state_t cal_state_r;
	logic [synth_cal_pkg::CAL_CNT_W-1:0] cal_cnt_r;
	logic done_n_r;
	logic store_a_r;
	logic store_b_r;
	logic pin_r;
	logic irq_r;
	synth_cal_pkg::synth_cfg_t cfg_r;
	logic [7:0] idx;
	logic req;
	logic wr;
	logic start_rise;
	logic cal_end;
	logic [synth_cal_pkg::CAL_CNT_W-1:0] cal_len;
	logic [1:0] div_code;
	logic [1:0] irq_clr;
	logic [1:0] irq_set;

	// Divider lookup, shared by the decoded output and the timer
	function automatic logic [8:0] cal_divider(input logic sel_new,
		input logic [1:0] code);
		logic [8:0] d;
		d = synth_cal_pkg::DIV_NEW_0;
		case ({sel_new, code})
			3'h4: d = synth_cal_pkg::DIV_NEW_0;
			3'h5: d = synth_cal_pkg::DIV_NEW_1;
			3'h6: d = synth_cal_pkg::DIV_NEW_2;
			3'h7: d = synth_cal_pkg::DIV_NEW_3;
			3'h0: d = synth_cal_pkg::DIV_OLD_0;
			3'h1: d = synth_cal_pkg::DIV_OLD_1;
			3'h2: d = synth_cal_pkg::DIV_OLD_2;
			3'h3: d = synth_cal_pkg::DIV_OLD_3;
			default: d = synth_cal_pkg::DIV_NEW_0;
		endcase
		return d;
	endfunction

	// Bus decode; registers sit in byte lane 0 of aligned words
	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign wr = req & ack_r & wb_we_i & wb_sel_i[0];
	assign div_code = tune_ctrl_r[synth_cal_pkg::POS_DIV_CODE +: 2];

	// Calibration length; legacy uses fixed periods, new scales the divider
	always_comb begin
		cal_len = '0;
		if (tune_ctrl_r[synth_cal_pkg::POS_ROUTINE]) begin
			cal_len = synth_cal_pkg::CAL_CNT_W'(NEW_CNT_PER_DIV *
				int'(cal_divider(1'b1, div_code)));
		end else begin
			case (div_code)
				2'h0: cal_len = synth_cal_pkg::CAL_CNT_W'(LEGACY_CNT_0);
				2'h1: cal_len = synth_cal_pkg::CAL_CNT_W'(LEGACY_CNT_1);
				default: cal_len = synth_cal_pkg::CAL_CNT_W'(LEGACY_CNT_2);
			endcase
		end
	end

	assign start_rise = tune_ctrl_r[synth_cal_pkg::POS_START] & ~start_prev_r;
	assign cal_end = (cal_state_r == synth_cal_pkg::CAL_RUN) &&
		(cal_cnt_r <= synth_cal_pkg::CAL_CNT_W'(1));

	// Acknowledge one cycle after request, drop the cycle after
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Read data captured with ack; unmapped addresses read zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_r <= 32'h0000_0000;
		end else if (req & ~ack_r) begin
			case (idx)
				synth_cal_pkg::IDX_LO_BIAS: rdata_r <= {24'h0, lo_bias_r};
				synth_cal_pkg::IDX_LOOP_GAIN: rdata_r <= {24'h0, loop_gain_r};
				synth_cal_pkg::IDX_TUNE_CTRL: rdata_r <= {24'h0, tune_ctrl_r};
				synth_cal_pkg::IDX_AMP_LEVEL: rdata_r <= {24'h0, amp_level_r};
				synth_cal_pkg::IDX_IRQ_STATUS:
					rdata_r <= {30'h0, irq_status_r};
				synth_cal_pkg::IDX_IRQ_MASK: rdata_r <= {30'h0, irq_mask_r};
				synth_cal_pkg::IDX_CAL_STATUS:
					rdata_r <= {30'h0, ~done_n_r, cal_state_r == synth_cal_pkg::CAL_RUN};
				synth_cal_pkg::IDX_PIN_ROUTE: rdata_r <= {28'h0, pin_route_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Bias register; reserved bits 5:3 stay zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lo_bias_r <= synth_cal_pkg::RST_LO_BIAS;
		end else if (wr && idx == synth_cal_pkg::IDX_LO_BIAS) begin
			lo_bias_r <= {wb_dat_i[7:6], 3'h0, wb_dat_i[2:0]};
		end
	end

	// Loop gain register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			loop_gain_r <= synth_cal_pkg::RST_LOOP_GAIN;
		end else if (wr && idx == synth_cal_pkg::IDX_LOOP_GAIN) begin
			loop_gain_r <= wb_dat_i[7:0];
		end
	end

	// Tune control; the start bit is plain storage, hardware never clears it
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tune_ctrl_r <= synth_cal_pkg::RST_TUNE_CTRL;
		end else if (wr && idx == synth_cal_pkg::IDX_TUNE_CTRL) begin
			tune_ctrl_r <= wb_dat_i[7:0];
		end
	end

	// Amplifier level register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			amp_level_r <= synth_cal_pkg::RST_AMP_LEVEL;
		end else if (wr && idx == synth_cal_pkg::IDX_AMP_LEVEL) begin
			amp_level_r <= wb_dat_i[7:0];
		end
	end

	// Mask and pin routing registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_mask_r <= synth_cal_pkg::RST_IRQ;
			pin_route_r <= synth_cal_pkg::RST_PIN_ROUTE;
		end else if (wr) begin
			if (idx == synth_cal_pkg::IDX_IRQ_MASK) begin
				irq_mask_r <= wb_dat_i[1:0];
			end
			if (idx == synth_cal_pkg::IDX_PIN_ROUTE) begin
				pin_route_r <= wb_dat_i[3:0];
			end
		end
	end

	// Sticky events; a set in the clearing cycle wins
	assign irq_clr = (wr && idx == synth_cal_pkg::IDX_IRQ_STATUS) ?
		wb_dat_i[1:0] : 2'h0;
	assign irq_set = {start_rise & (cal_state_r == synth_cal_pkg::CAL_IDLE),
		cal_end};
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_status_r <= synth_cal_pkg::RST_IRQ;
		end else begin
			irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
		end
	end

	// Interrupt level from unmasked status
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_mask_r);
		end
	end

	// Previous start bit for edge detection
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			start_prev_r <= 1'b0;
		end else begin
			start_prev_r <= tune_ctrl_r[synth_cal_pkg::POS_START];
		end
	end

	// Calibration timer; an edge during a run is ignored
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cal_state_r <= synth_cal_pkg::CAL_IDLE;
			cal_cnt_r <= '0;
		end else begin
			case (cal_state_r)
				synth_cal_pkg::CAL_IDLE: begin
					if (start_rise) begin
						cal_state_r <= synth_cal_pkg::CAL_RUN;
						cal_cnt_r <= cal_len;
					end
				end
				synth_cal_pkg::CAL_RUN: begin
					if (cal_end) begin
						cal_state_r <= synth_cal_pkg::CAL_IDLE;
						cal_cnt_r <= '0;
					end else begin
						cal_cnt_r <= cal_cnt_r - synth_cal_pkg::CAL_CNT_W'(1);
					end
				end
				default: begin
					cal_state_r <= synth_cal_pkg::CAL_IDLE;
					cal_cnt_r <= '0;
				end
			endcase
		end
	end

	// Result store strobes at the end of a run
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			store_a_r <= 1'b0;
			store_b_r <= 1'b0;
		end else begin
			store_a_r <= cal_end &
				(tune_ctrl_r[synth_cal_pkg::POS_STORE_BOTH] | ~freq_bank_sel);
			store_b_r <= cal_end &
				(tune_ctrl_r[synth_cal_pkg::POS_STORE_BOTH] | freq_bank_sel);
		end
	end

	// Done flag, low once a run completes, high again on a new start
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			done_n_r <= 1'b1;
		end else if (cal_state_r == synth_cal_pkg::CAL_IDLE && start_rise) begin
			done_n_r <= 1'b1;
		end else if (cal_end) begin
			done_n_r <= 1'b0;
		end
	end

	// Status pin mux; other sources live outside this slice and read zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin_r <= 1'b0;
		end else begin
			case (pin_route_r)
				synth_cal_pkg::PIN_SRC_ONE: pin_r <= 1'b1;
				synth_cal_pkg::PIN_SRC_CAL_DONE: pin_r <= done_n_r;
				default: pin_r <= 1'b0;
			endcase
		end
	end

	// Decoded settings, registered so outputs come from flops
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_r <= '0;
		end else begin
			cfg_r.presc_bias <= lo_bias_r[synth_cal_pkg::POS_PRESC_BIAS +: 2];
			cfg_r.lo_drive <= lo_bias_r[synth_cal_pkg::POS_LO_DRIVE +: 3];
			cfg_r.loop_gain <= loop_gain_r;
			cfg_r.store_both <= tune_ctrl_r[synth_cal_pkg::POS_STORE_BOTH];
			cfg_r.routine_new <= tune_ctrl_r[synth_cal_pkg::POS_ROUTINE];
			cfg_r.cal_div <= cal_divider(
				tune_ctrl_r[synth_cal_pkg::POS_ROUTINE], div_code);
			// start value is code plus one
			cfg_r.tune_dac_seed <= {1'b0,
				tune_ctrl_r[synth_cal_pkg::POS_DAC_SEED +: 3]} + 4'h1;
			cfg_r.strong_amp_level <= amp_level_r[synth_cal_pkg::POS_STRONG +: 4];
			cfg_r.weak_amp_level <= amp_level_r[synth_cal_pkg::POS_WEAK +: 4];
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;
	assign cfg = cfg_r;
	assign cal_busy = (cal_state_r == synth_cal_pkg::CAL_RUN);
	assign cal_store_a = store_a_r;
	assign cal_store_b = store_b_r;
	assign cal_done_n = done_n_r;
	assign status_pin = pin_r;
	assign irq = irq_r;
endmodule

// ---- bench/synth_cal_regs_sva.sv ----
// Assertion checker for the calibration register slice
`timescale 1ns/10ps
module synth_cal_regs_sva #(
	parameter int LEGACY_CNT_0 = synth_cal_pkg::LEGACY_REF_0,
	parameter int LEGACY_CNT_1 = synth_cal_pkg::LEGACY_REF_1,
	parameter int LEGACY_CNT_2 = synth_cal_pkg::LEGACY_REF_2,
	parameter int NEW_CNT_PER_DIV = synth_cal_pkg::NEW_REF_PER_DIV
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic freq_bank_sel,
	input wire synth_cal_pkg::synth_cfg_t cfg,
	input wire logic cal_busy,
	input wire logic cal_store_a,
	input wire logic cal_store_b,
	input wire logic cal_done_n
);
	logic up_r;
	logic [17:0] len_r;
	int exp_len;
	// Decoded settings are only valid one edge after reset release
	always_ff @(posedge mclk) up_r <= resetn;
	// Length of the current run in busy cycles
	always_ff @(posedge mclk) len_r <= cal_busy ? len_r + 18'h1 : 18'h0;
	// Expected length from the decoded divider and routine
	always_comb begin
		if (cfg.routine_new)
			exp_len = NEW_CNT_PER_DIV * int'(cfg.cal_div);
		else if (cfg.cal_div == 9'h050)
			exp_len = LEGACY_CNT_0;
		else if (cfg.cal_div == 9'h080)
			exp_len = LEGACY_CNT_1;
		else
			exp_len = LEGACY_CNT_2;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence run_end;
		$fell(cal_busy);
	endsequence
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	AST_ACK_LATENCY: assert property (bus_req |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_HAS_REQ: assert property (wb_ack_o |->
		$past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	// Settings move only one edge after an acknowledged write
	AST_CFG_BY_WRITE: assert property (up_r && !wb_ack_o |->
		##2 $stable(cfg))
		else $error("settings changed without a write");
	// Done flag goes back high only as a new run begins
	AST_DONE_ON_START: assert property ($rose(cal_done_n) |->
		$rose(cal_busy))
		else $error("done flag raised without a start");
	AST_DATA_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_SEED_RANGE: assert property (up_r |->
		cfg.tune_dac_seed >= 4'h1 && cfg.tune_dac_seed <= 4'h8)
		else $error("dac seed out of range");
	AST_RUN_LEN: assert property (run_end |-> len_r == exp_len)
		else $error("calibration length wrong");
	AST_DONE_AT_END: assert property (run_end |-> !cal_done_n)
		else $error("done flag missing at run end");
	AST_STORE_ONLY_END: assert property ((cal_store_a || cal_store_b) |->
		$fell(cal_busy))
		else $error("store outside run end");
	AST_STORE_BOTH: assert property (run_end ##0 cfg.store_both |->
		cal_store_a && cal_store_b)
		else $error("store both not applied");
	AST_STORE_ONE: assert property (run_end ##0 !cfg.store_both |->
		cal_store_b == $past(freq_bank_sel) && cal_store_a != cal_store_b)
		else $error("single store wrong set");
endmodule

// ---- bench/test_synth_cal_regs.sv ----
// Testbench for the calibration register slice
`timescale 1ns/10ps
module test_synth_cal_regs;
	logic mclk = 1'b0, resetn = 1'b0, freq_bank_sel = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic cal_busy, cal_store_a, cal_store_b, cal_done_n, status_pin, irq;
	logic [7:0] q;
	synth_cal_pkg::synth_cfg_t cfg;
	int n_mismatch = 0, tests_run = 0, cyc = 0, n_a = 0, n_b = 0;
	logic [8:0] divs [8] = '{9'h008, 9'h010, 9'h028, 9'h050,
		9'h050, 9'h080, 9'h0a0, 9'h100};
	synth_cal_regs #(.LEGACY_CNT_0(20), .LEGACY_CNT_1(30),
		.LEGACY_CNT_2(40), .NEW_CNT_PER_DIV(4)) u_synth_cal_regs (
		.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .freq_bank_sel, .cfg,
		.cal_busy, .cal_store_a, .cal_store_b, .cal_done_n, .status_pin,
		.irq);
	always #4 mclk = ~mclk;
	// Store pulse counters and hang guard
	always @(posedge mclk) begin
		n_a += (cal_store_a === 1'b1);
		n_b += (cal_store_b === 1'b1);
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task cmp(input logic [63:0] got, input logic [63:0] exp, input string s);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	// One classic cycle; entered right after a rising edge
	// Waits for ack with no limit of its own; the hang guard ends a stall
	task wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'h1;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		cmp(q, exp, "read");
	endtask
	// Clear start then set it, and measure the busy time
	task cal_run(input logic [7:0] v, input int len);
		int n;
		n = 0;
		wb(1'b1, 8'h1b, v & 8'h7f);
		wb(1'b1, 8'h1b, v);
		while (cal_busy !== 1'b1 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (cal_busy === 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		cmp(n, len, "run length");
	endtask
	task finish_test();
		$display("compared %0d, mismatched %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(8'h19, 8'h45);
		rd(8'h1a, 8'h86);
		rd(8'h1b, 8'h0d);
		rd(8'h1c, 8'h0f);
		cmp(cfg, {2'h1, 3'h5, 8'h86, 2'h1, 9'h008, 4'h6, 8'h0f}, "cfg");
		$display("test reset values done");
		wb(1'b1, 8'h19, 8'hff);
		rd(8'h19, 8'hc7);
		wb(1'b1, 8'h1a, 8'h92);
		rd(8'h1a, 8'h92);
		// Power set through the strong nibble only, weak array off
		wb(1'b1, 8'h1c, 8'h50);
		rd(8'h1c, 8'h50);
		cmp({cfg.presc_bias, cfg.lo_drive, cfg.strong_amp_level,
			cfg.weak_amp_level}, {2'h3, 3'h7, 8'h50}, "decode");
		wb(1'b1, 8'h3f, 8'hff);
		rd(8'h3f, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h1b, {2'h0, i[1:0], ~i[2], i[2:0]});
			@(posedge mclk);
			cmp(cfg.cal_div, divs[i], "divider");
			cmp(cfg.tune_dac_seed, i + 1, "seed");
		end
		$display("test decode done");
		wb(1'b1, 8'h31, 8'h01);
		wb(1'b1, 8'h33, 8'h05);
		freq_bank_sel <= 1'b1;
		cal_run(8'h8c, 32);
		cmp({irq, cal_done_n, status_pin}, 3'h4, "done flags");
		cmp({n_a, n_b}, {32'h0, 32'h1}, "store set b");
		rd(8'h30, 8'h03);
		rd(8'h32, 8'h02);
		wb(1'b1, 8'h1b, 8'h8c);
		repeat (4) @(posedge mclk);
		cmp(cal_busy, 1'b0, "restart refused");
		wb(1'b1, 8'h30, 8'h01);
		rd(8'h30, 8'h02);
		cmp(irq, 1'b0, "irq cleared");
		wb(1'b1, 8'h31, 8'h03);
		rd(8'h31, 8'h03);
		cmp(irq, 1'b1, "irq unmasked");
		wb(1'b1, 8'h30, 8'h02);
		rd(8'h30, 8'h00);
		cmp(irq, 1'b0, "irq cleared");
		cal_run(8'hd4, 30);
		cmp({n_a, n_b}, {32'h1, 32'h2}, "store both");
		freq_bank_sel <= 1'b0;
		cal_run(8'hb4, 40);
		cmp({n_a, n_b}, {32'h2, 32'h2}, "store set a");
		wb(1'b1, 8'h33, 8'h01);
		repeat (2) @(posedge mclk);
		cmp(status_pin, 1'b1, "pin forced high");
		$display("test calibration done");
		finish_test();
	end
endmodule
bind synth_cal_regs synth_cal_regs_sva #(.LEGACY_CNT_0(LEGACY_CNT_0),
	.LEGACY_CNT_1(LEGACY_CNT_1), .LEGACY_CNT_2(LEGACY_CNT_2),
	.NEW_CNT_PER_DIV(NEW_CNT_PER_DIV)) u_synth_cal_regs_sva (
	.mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
	.freq_bank_sel, .cfg, .cal_busy, .cal_store_a, .cal_store_b,
	.cal_done_n);
